// [verilog/tmr_pkg.sv]
// Constants shared by the timer core and its bus-side controller.
// Assumes both ends are compiled after this package.
package tmr_pkg;
  // Byte locations on the 8-bit processor data path.
  localparam logic [3:0] LOC_CNT_LO = 4'h0;
  localparam logic [3:0] LOC_CNT_HI = 4'h1;
  localparam logic [3:0] LOC_CMPA_LO = 4'h2;
  localparam logic [3:0] LOC_CMPB_LO = 4'h4;
  localparam logic [3:0] LOC_CMPC_LO = 4'h6;
  localparam logic [3:0] LOC_CAP_LO = 4'h8;
  localparam logic [3:0] LOC_CAP_HI = 4'h9;
  localparam logic [3:0] LOC_CTRL_A = 4'ha;
  localparam logic [3:0] LOC_CTRL_B = 4'hb;
  localparam logic [3:0] LOC_FLAGS = 4'hc;
  // Field positions.
  localparam int CTRL_A_WGM_LSB = 0;
  localparam int CTRL_B_CS_LSB = 0;
  localparam int CTRL_B_WGM_LSB = 3;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CAP_BIT = 1;
  // Values after reset.
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // Counter extremes and fixed tops.
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  // Clock-source codes.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Controller register map (word indices) and its register count.
  localparam int HOST_REGS = 8;
  localparam logic [3:0] HOST_IDX_CTRL_A = 4'h5;
endpackage : tmr_pkg

// [verilog/tmr_bus_if.sv]
// Byte-wide processor data path between the timer and its controller.
// Assumes one clock shared by both ends; read data follows a read strobe by one cycle.
`timescale 1ns/1ps
`default_nettype none
interface tmr_bus_if;
  logic [3:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dev (input addr, input wr, input rd, input wdata, output rdata);
  modport cpu (output addr, output wr, output rd, output wdata, input rdata);
endinterface : tmr_bus_if
`default_nettype wire

// [verilog/tmr_core.sv]
// Sixteen-bit timer/counter core reached over a byte-wide data path.
// Assumes the processor side keeps to the byte ordering and never interleaves
// two split accesses; external inputs arrive asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 16-bit registers move as two byte accesses.
// - one shared holding register stages upper bytes.
// - low-byte write loads holding plus low together.
// - low-byte read copies upper byte into holding.
// - compare reads return upper byte directly.
// - write high first; read low first.
// - software masks interrupts around split accesses.
// - one staged upper byte may serve several writes.
// - clock-source field zero stops the counter.
// - each tick clears, increments or decrements.
// - counter readable and writable at any time.
// - processor write beats any count action.
// - mode field split across control A and B.
// - overflow flag set at mode-defined point.
// - upper counter location reaches holding register only.
// - top and bottom indications are produced.
// - bottom 0x0000, max 0xFFFF, top per mode.
// - capture reads go through the holding register.
module tmr_core
  import tmr_pkg::*;
#(
  parameter int PRESC_W = 10
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Processor data path.
  tmr_bus_if.dev bus,
  // External pins.
  input wire logic ext_clk_i,
  input wire logic capture_i,
  // Status towards the waveform logic and interrupt controller.
  output logic overflow_flag_o,
  output logic capture_flag_o,
  output logic at_top_o,
  output logic at_bottom_o
);
  // The widest prescaler tap divides by 1024, so narrower prescalers are refused.
  if (PRESC_W < 10) begin : g_presc_check
    $error("PRESC_W must cover a divide by 1024");
  end

  logic [15:0] count_value;
  logic [7:0] hold;
  logic [15:0] compare_registers [3];
  logic [15:0] capture_register;
  logic [7:0] control_reg_a;
  logic [7:0] control_reg_b;
  logic [3:0] waveform_mode_field;
  logic [2:0] clock_source_select;
  logic [PRESC_W-1:0] presc;
  logic [1:0] ext_sync;
  logic ext_prev;
  logic [1:0] cap_sync;
  logic cap_prev;
  logic count_up;
  logic timer_tick;
  logic [15:0] top_value;
  logic updown;
  logic icr_top;
  logic cnt_write;
  logic [7:0] flag_clear;
  logic ovf_event;
  logic cap_event;

  function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] ocra, input logic [15:0] icr);
    unique case (m)
      4'h1, 4'h5: mode_top = TOP_8BIT;
      4'h2, 4'h6: mode_top = TOP_9BIT;
      4'h3, 4'h7: mode_top = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: mode_top = ocra;
      4'h8, 4'ha, 4'hc, 4'he: mode_top = icr;
      default: mode_top = CNT_MAX;
    endcase
  endfunction : mode_top

  assign waveform_mode_field = {control_reg_b[CTRL_B_WGM_LSB+:2], control_reg_a[CTRL_A_WGM_LSB+:2]};
  assign clock_source_select = control_reg_b[CTRL_B_CS_LSB+:3];
  assign top_value = mode_top(waveform_mode_field, compare_registers[0], capture_register);
  assign updown = waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
  assign icr_top = waveform_mode_field inside {4'h8, 4'ha, 4'hc, 4'he};
  assign cnt_write = bus.wr && (bus.addr == LOC_CNT_LO);
  assign flag_clear = (bus.wr && bus.addr == LOC_FLAGS) ? bus.wdata : 8'h00;

  // Prescaler and external-edge sampling feed the tick selector.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync <= 2'b00;
      ext_prev <= 1'b0;
      cap_sync <= 2'b00;
      cap_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], ext_clk_i};
      ext_prev <= ext_sync[1];
      cap_sync <= {cap_sync[0], capture_i};
      cap_prev <= cap_sync[1];
    end
  end

  always_comb begin
    unique case (clock_source_select)
      CS_STOP: timer_tick = 1'b0;
      CS_DIRECT: timer_tick = 1'b1;
      CS_DIV8: timer_tick = &presc[2:0];
      CS_DIV64: timer_tick = &presc[5:0];
      CS_DIV256: timer_tick = &presc[7:0];
      CS_DIV1024: timer_tick = &presc[9:0];
      CS_EXT_FALL: timer_tick = ext_prev && !ext_sync[1];
      CS_EXT_RISE: timer_tick = !ext_prev && ext_sync[1];
    endcase
  end

  // Counter: a processor write overrides clear and count in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value <= RST_COUNT;
    end else if (cnt_write) begin
      count_value <= {hold, bus.wdata};
    end else if (timer_tick) begin
      if (!updown) begin
        count_value <= (count_value == top_value) ? CNT_BOTTOM : count_value + 16'h0001;
      end else if (count_up) begin
        count_value <= (count_value >= top_value) ? count_value - 16'h0001 : count_value + 16'h0001;
      end else begin
        count_value <= (count_value == CNT_BOTTOM) ? count_value + 16'h0001 : count_value - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_up <= 1'b1;
    end else if (!updown) begin
      count_up <= 1'b1;
    end else if (timer_tick && !cnt_write) begin
      if (count_up && count_value >= top_value) begin
        count_up <= 1'b0;
      end else if (!count_up && count_value == CNT_BOTTOM) begin
        count_up <= 1'b1;
      end
    end
  end

  // Overflow point: MAX in normal and clear-on-match modes, top in fast modes, bottom in dual-slope modes.
  always_comb begin
    if (!timer_tick || cnt_write) begin
      ovf_event = 1'b0;
    end else if (updown) begin
      ovf_event = (count_value == CNT_BOTTOM) && !count_up;
    end else if (waveform_mode_field inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf}) begin
      ovf_event = (count_value == top_value);
    end else begin
      ovf_event = (count_value == CNT_MAX);
    end
  end

  assign cap_event = !cap_prev && cap_sync[1] && !icr_top;

  // Flags: hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_o <= 1'b0;
    end else begin
      overflow_flag_o <= ovf_event || (overflow_flag_o && !flag_clear[FLAG_OVF_BIT]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_flag_o <= 1'b0;
    end else begin
      capture_flag_o <= cap_event || (capture_flag_o && !flag_clear[FLAG_CAP_BIT]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      at_top_o <= 1'b0;
      at_bottom_o <= 1'b1;
    end else begin
      at_top_o <= (count_value == top_value);
      at_bottom_o <= (count_value == CNT_BOTTOM);
    end
  end

  // Shared holding register: staged by upper writes, loaded by count and capture low-byte reads.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold <= RST_HOLD;
    end else if (bus.wr && bus.addr[0] && bus.addr < LOC_CTRL_A) begin
      hold <= bus.wdata;
    end else if (bus.rd && bus.addr == LOC_CNT_LO) begin
      hold <= count_value[15:8];
    end else if (bus.rd && bus.addr == LOC_CAP_LO) begin
      hold <= capture_register[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_registers <= '{default: RST_COUNT};
    end else if (bus.wr && !bus.addr[0] && bus.addr >= LOC_CMPA_LO && bus.addr <= LOC_CMPC_LO) begin
      compare_registers[bus.addr[2:1] - 2'd1] <= {hold, bus.wdata};
    end
  end

  // Capture register is written by software only while it defines top.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_register <= RST_COUNT;
    end else if (bus.wr && bus.addr == LOC_CAP_LO && icr_top) begin
      capture_register <= {hold, bus.wdata};
    end else if (cap_event) begin
      capture_register <= count_value;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_reg_a <= RST_CTRL;
      control_reg_b <= RST_CTRL;
    end else if (bus.wr && bus.addr == LOC_CTRL_A) begin
      control_reg_a <= bus.wdata;
    end else if (bus.wr && bus.addr == LOC_CTRL_B) begin
      control_reg_b <= bus.wdata;
    end
  end

  // Read data is registered and valid in the cycle after the read strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        LOC_CNT_LO: bus.rdata <= count_value[7:0];
        LOC_CNT_HI, LOC_CAP_HI: bus.rdata <= hold;
        4'h2, 4'h4, 4'h6: bus.rdata <= compare_registers[bus.addr[2:1] - 2'd1][7:0];
        4'h3, 4'h5, 4'h7: bus.rdata <= compare_registers[bus.addr[2:1] - 2'd1][15:8];
        LOC_CAP_LO: bus.rdata <= capture_register[7:0];
        LOC_CTRL_A: bus.rdata <= control_reg_a;
        LOC_CTRL_B: bus.rdata <= control_reg_b;
        LOC_FLAGS: bus.rdata <= {6'h00, capture_flag_o, overflow_flag_o};
        default: bus.rdata <= 8'h00;
      endcase
    end
  end
endmodule : tmr_core
`default_nettype wire

// [verilog/tmr_host.sv]
// Processor-side controller: turns Wishbone word accesses into byte accesses.
// Assumes it is the only master on the byte path, so split accesses never interleave.
`timescale 1ns/1ps
`default_nettype none
module tmr_host
  import tmr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Byte path to the timer.
  tmr_bus_if.cpu bus
);
  typedef enum {S_IDLE, S_W_HI, S_W_LO, S_R_LO, S_R_HI, S_R_END, S_ACK} tmr_state_t;
  tmr_state_t state;
  logic [3:0] idx;
  logic [15:0] wval;
  logic wide;

  // Indices below the control registers are 16-bit; ordering keeps the shared holding register coherent.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      idx <= 4'h0;
      wval <= 16'h0000;
      wide <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (cyc_i && stb_i) begin
            idx <= adr_i[5:2];
            wval <= dat_i[15:0];
            wide <= adr_i[5:2] < HOST_IDX_CTRL_A;
            if (adr_i[5:2] >= 4'(HOST_REGS)) begin
              state <= S_ACK;
            end else if (we_i && sel_i[0]) begin
              state <= (adr_i[5:2] < HOST_IDX_CTRL_A) ? S_W_HI : S_W_LO;
            end else if (we_i) begin
              state <= S_ACK;
            end else begin
              state <= S_R_LO;
            end
          end
        end
        S_W_HI: state <= S_W_LO;
        S_W_LO: state <= S_ACK;
        S_R_LO: state <= wide ? S_R_HI : S_R_END;
        S_R_HI: state <= S_R_END;
        S_R_END: state <= S_ACK;
        S_ACK: state <= S_IDLE;
      endcase
    end
  end

  // Location of byte k within index i: 16-bit pairs sit at 2i, control and flags follow.
  always_comb begin
    bus.wr = (state == S_W_HI) || (state == S_W_LO);
    bus.rd = (state == S_R_LO) || (state == S_R_HI);
    bus.wdata = (state == S_W_HI) ? wval[15:8] : wval[7:0];
    if (wide) begin
      bus.addr = {idx[2:0], (state == S_W_HI) || (state == S_R_HI)};
    end else begin
      bus.addr = LOC_CTRL_A + (idx - HOST_IDX_CTRL_A);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (state == S_IDLE) begin
      dat_o <= 32'h0000_0000;
    end else if (state == S_R_HI) begin
      dat_o[7:0] <= bus.rdata;
    end else if (state == S_R_END) begin
      if (wide) begin
        dat_o[15:8] <= bus.rdata;
      end else begin
        dat_o[7:0] <= bus.rdata;
      end
    end
  end

  assign ack_o = (state == S_ACK);
endmodule : tmr_host
`default_nettype wire

// [tb/tmr_bus_sva.sv]
// Checker for the byte path between the timer controller and the timer core.
// Assumes it watches the one interface that joins both ends, on their shared clock.
`timescale 1ns/1ps
`default_nettype none
module tmr_bus_sva
  import tmr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte path.
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  logic [7:0] hold_q;
  logic hold_ok;
  logic [15:0] cnt_q;
  logic cnt_ok;
  logic [7:0] cnt_lo;
  logic [1:0] wgm_lo;
  logic [4:0] ctlb;
  logic run;
  assign cnt_lo = cnt_q[7:0];
  // Only direct clocking in the plain up-counting mode is followed cycle by cycle.
  assign run = ctlb[2:0] == CS_DIRECT && ctlb[4:3] == 2'h0 && wgm_lo == 2'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wgm_lo <= 2'h0;
      ctlb <= 5'h00;
    end else if (wr && addr == LOC_CTRL_A) begin
      wgm_lo <= wdata[1:0];
    end else if (wr && addr == LOC_CTRL_B) begin
      ctlb <= wdata[4:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= RST_HOLD;
      hold_ok <= 1'b1;
    end else if (wr && addr[0] && addr <= LOC_CAP_HI) begin
      hold_q <= wdata;
      hold_ok <= 1'b1;
    end else if (rd && addr == LOC_CNT_LO) begin
      hold_q <= cnt_q[15:8];
      hold_ok <= cnt_ok;
    end else if (rd && addr == LOC_CAP_LO) begin
      hold_ok <= 1'b0;
    end
  end
  // The count is known only while stopped or counting every clock from a written value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= RST_COUNT;
      cnt_ok <= 1'b1;
    end else if (wr && addr == LOC_CNT_LO) begin
      cnt_q <= {hold_q, wdata};
      cnt_ok <= hold_ok && (ctlb[2:0] == CS_STOP || run);
    end else if (wr && (addr == LOC_CTRL_A || addr == LOC_CTRL_B)) begin
      cnt_ok <= 1'b0;
    end else if (run) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  a_rd_wr_excl:
    assert property (!(wr && rd)) else $error("read and write strobes overlap");
  a_write_hi_first:
    assert property (wr && !addr[0] && addr < LOC_CTRL_A |-> $past(wr) && $past(addr) == (addr | 4'h1))
    else $error("low byte written without upper byte just before");
  a_read_lo_first:
    assert property (rd && addr[0] && addr < LOC_CTRL_A |-> $past(rd) && $past(addr) == (addr & 4'he))
    else $error("upper byte read without low byte just before");
  a_rdata_holds:
    assert property (!rd |=> $stable(rdata)) else $error("read data changed without a read");
  a_cnt_low_read:
    assert property (rd && addr == LOC_CNT_LO && cnt_ok |=> rdata == $past(cnt_lo))
    else $error("count low byte differs from expected count");
  a_hold_read:
    assert property (rd && (addr == LOC_CNT_HI || addr == LOC_CAP_HI) && hold_ok |=> rdata == $past(hold_q))
    else $error("upper location did not return the holding byte");
  a_ctrl_a_read:
    assert property (rd && addr == LOC_CTRL_A |=> rdata[1:0] == $past(wgm_lo))
    else $error("control A mode bits differ");
  a_ctrl_b_read:
    assert property (rd && addr == LOC_CTRL_B |=> rdata[4:0] == $past(ctlb))
    else $error("control B fields differ");
  a_reset_quiet:
    assert property ($fell(rst_i) |-> !wr && !rd && rdata == 8'h00)
    else $error("byte path not idle after reset");
endmodule : tmr_bus_sva
`default_nettype wire

// [tb/tb_timer16_byte_access_counter.sv]
// Testbench: a Wishbone master drives the controller, which drives the timer core.
// Assumes one 50 MHz clock; the bench drives the external count and capture pins itself.
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_byte_access_counter
  import tmr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [5:0] adr_i = 6'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic at_top;
  logic at_bot;
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  logic ovf_flag;
  logic cap_flag;
  int fail_count = 0;
  int cmp_count = 0;
  always #10 clk_i = ~clk_i;
  tmr_bus_if u_tmr_bus_if ();
  tmr_core u_tmr_core (.clk_i(clk_i), .rst_i(rst_i), .bus(u_tmr_bus_if), .ext_clk_i(ext_pin), .capture_i(cap_pin),
    .overflow_flag_o(ovf_flag), .capture_flag_o(cap_flag), .at_top_o(at_top), .at_bottom_o(at_bot));
  tmr_host u_tmr_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .bus(u_tmr_bus_if));
  tmr_bus_sva u_tmr_bus_sva (.clk_i(clk_i), .rst_i(rst_i), .addr(u_tmr_bus_if.addr), .wr(u_tmr_bus_if.wr),
    .rd(u_tmr_bus_if.rd), .wdata(u_tmr_bus_if.wdata), .rdata(u_tmr_bus_if.rdata));
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; the request stands until ack is seen at a rising edge.
  task automatic wb(input logic w, input logic [3:0] idx, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 40) begin
      fail_count++;
      $display("mismatch at %0t: no acknowledge", $time);
    end
  endtask : wb
  task automatic wr16(input logic [3:0] idx, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, idx, d, q);
  endtask : wr16
  task automatic rd16(input logic [3:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    wb(1'b0, idx, 16'h0000, q);
    chk(q, exp);
  endtask : rd16
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd16(4'h0, RST_COUNT);
    rd16(4'h6, 16'h0000);
    chk({14'h0, at_top, at_bot}, 16'h0001);
    wr16(4'h0, 16'h01ff);
    repeat (5) @(posedge clk_i);
    rd16(4'h0, 16'h01ff);
    for (int k = 1; k < 4; k++) begin
      wr16(k[3:0], 16'(k * 16'h1357));
    end
    // The count write leaves a different byte staged in the holding register.
    wr16(4'h0, 16'hab00);
    for (int k = 1; k < 4; k++) begin
      rd16(k[3:0], 16'(k * 16'h1357));
    end
    rd16(4'h0, 16'hab00);
    wr16(4'h4, 16'h5a5a);
    rd16(4'h4, 16'h0000);
    wr16(4'h6, 16'h0018);
    wr16(4'h4, 16'h4321);
    rd16(4'h4, 16'h4321);
    rd16(4'h6, 16'h0018);
    wr16(4'h6, 16'h0000);
    wr16(4'h5, 16'h0002);
    wr16(4'h0, 16'h01ff);
    repeat (2) @(posedge clk_i);
    chk({14'h0, at_top, at_bot}, 16'h0002);
    wr16(4'h0, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk({14'h0, at_top, at_bot}, 16'h0001);
    rd16(4'h5, 16'h0002);
    wr16(4'h5, 16'h0000);
    wr16(4'h6, 16'h0001);
    // Three clocks pass between the load and the sampled low-byte read.
    wr16(4'h0, 16'hfffd);
    rd16(4'h0, 16'h0000);
    rd16(4'h7, 16'h0001);
    chk({14'h0, cap_flag, ovf_flag}, 16'h0001);
    wr16(4'h7, 16'h0001);
    rd16(4'h7, 16'h0000);
    wr16(4'h6, 16'h0000);
    rd16(4'h8, 16'h0000);
    // Three rising edges on the external count pin, each held well past the pin synchroniser.
    wr16(4'h0, 16'h0000);
    wr16(4'h6, 16'h0007);
    repeat (3) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    wr16(4'h6, 16'h0000);
    rd16(4'h0, 16'h0003);
    // A rising edge on the capture pin copies the stopped count.
    cap_pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    cap_pin <= 1'b0;
    rd16(4'h4, 16'h0003);
    chk({14'h0, cap_flag, ovf_flag}, 16'h0002);
    // Sixty-four clocks pass with the divide-by-8 source selected, so eight ticks land.
    wr16(4'h0, 16'h0000);
    wr16(4'h6, 16'h0002);
    repeat (60) @(posedge clk_i);
    wr16(4'h6, 16'h0000);
    rd16(4'h0, 16'h0008);
    stop_test();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    fail_count++;
    $display("mismatch at %0t: run did not finish", $time);
    stop_test();
  end
endmodule : tb_timer16_byte_access_counter
`default_nettype wire
